/* hdl/lpif_dbi.sv */
// per-byte data inversion encode and decode, combinational
// assumes caller registers the results
`timescale 1ns/1ps
module lpif_dbi (
  input wire logic [15:0] wrData,
  input wire logic [1:0] wrDmi,
  input wire logic [15:0] rdData,
  input wire logic dbiOn,
  output logic [15:0] wrPlain,
  output logic [1:0] wrMask,
  output logic [15:0] rdCoded,
  output logic [1:0] rdDmi
);
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_byte
      logic ones;
      // invert when more than half the bits are high, a cheap stand-in for the dc criterion
      assign ones = ($countones(rdData[8*b +: 8]) > 4);
      assign rdDmi[b] = dbiOn & ones;
      assign rdCoded[8*b +: 8] = rdDmi[b] ? ~rdData[8*b +: 8] : rdData[8*b +: 8];
      // in dbi mode dmi means inverted, otherwise it masks the byte
      assign wrPlain[8*b +: 8] = (dbiOn & wrDmi[b]) ? ~wrData[8*b +: 8] : wrData[8*b +: 8];
      assign wrMask[b] = ~dbiOn & wrDmi[b];
    end
  endgenerate
endmodule

/* hdl/lpif_die.sv */
// pin level behaviour of one channel of the memory die
// assumes ck, dqs and all pins are asynchronous to core_clk, ck at least 4x slower
`timescale 1ns/1ps
// Summary of operation
// - capture command inputs on rising ck crossing
// - cke low disables command sampling and drivers
// - cke edges enter, exit power down
// - ca with cs decoded as commands
// - odt pin ignored, mode bits rule
// - read strobe driven edge aligned with data
// - two bytes, own strobe and dmi
// - dmi high marks an inverted byte
// - mode bit picks inversion or masking
// - one reset clears whole die except the memory array
// - burst 16 default, 32, on-the-fly
// - data twice per clock, command once
// - programmable read and write latency
// - all-bank, per-bank, self refresh, masking
// - commands span two cycles
module lpif_die (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ckPin,
  input wire logic ckePin,
  input wire logic csPin,
  input wire logic [5:0] caPin,
  input wire logic odtCaPin,
  input wire logic [15:0] dqIn,
  output logic [15:0] dqOut,
  output logic [15:0] dqOe,
  input wire logic [1:0] dqsIn,
  output logic [1:0] dqsOut,
  output logic [1:0] dqsOe,
  input wire logic [1:0] dmiIn,
  output logic [1:0] dmiOut,
  output logic [1:0] dmiOe,
  output logic powerDown,
  output logic selfRefresh,
  output logic [3:0] readLat,
  output logic [3:0] writeLat,
  output logic [1:0] odtSetting,
  output logic refreshPulse,
  output logic [2:0] refreshBank,
  output logic refreshAll,
  output logic zqBusy,
  output logic [7:0] bankMask,
  output logic [7:0] segMask
);
  logic ckS, ckeS, csS, ckD_q;
  logic [5:0] caS;
  logic [15:0] dqS;
  logic [1:0] dqsS, dmiS, dqsD_q;
  lpif_sync #(.W(9)) u_syncCmd (.core_clk(core_clk), .rst_b(rst_b), .din({ckPin, ckePin, csPin, caPin}),
    .dout({ckS, ckeS, csS, caS}));
  lpif_sync #(.W(20)) u_syncDat (.core_clk(core_clk), .rst_b(rst_b), .din({dqIn, dqsIn, dmiIn}),
    .dout({dqS, dqsS, dmiS}));

  logic ckRise, ckFall, ckEdge, cmdEn, ckeD_q;
  assign ckRise = ckS & ~ckD_q;
  assign ckFall = ~ckS & ckD_q;
  assign ckEdge = ckRise | ckFall;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ckD_q <= 1'b0;
      dqsD_q <= 2'h0;
      ckeD_q <= 1'b0;
    end else begin
      ckD_q <= ckS;
      dqsD_q <= dqsS;
      if (ckRise) ckeD_q <= ckeS;
    end
  end
  // only rising crossings sample command pins, and only with cke high
  assign cmdEn = ckRise & ckeS;

  // power down takes inverted cke at each rising ck crossing; cke is part of every command
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) powerDown <= 1'b1;
    else if (ckRise) powerDown <= ~ckeS;
  end

  lpif_pkg::lpif_state_t st_q;
  logic [5:0] op_q, arg_q, beats_q;
  logic [3:0] lat_q;
  logic [1:0] mrBl_q;
  logic mrDmi_q, blSel_q, masked_q;
  logic [lpif_pkg::ADDR_W-1:0] addr_q;
  logic [7:0] openRows_q;
  logic [15:0] mem [lpif_pkg::MEM_DEPTH];
  logic [15:0] wrPlain, rdCoded, rdWord;
  logic [1:0] wrMask, rdDmi;
  logic isRd, isWr;
  assign isRd = (op_q == lpif_pkg::OP_RD);
  assign isWr = (op_q == lpif_pkg::OP_WR) | (op_q == lpif_pkg::OP_MWR);

  assign rdWord = mem[addr_q];
  lpif_dbi u_dbi (.wrData(dqS), .wrDmi(dmiS), .rdData(rdWord), .dbiOn(mrDmi_q),
    .wrPlain(wrPlain), .wrMask(wrMask), .rdCoded(rdCoded), .rdDmi(rdDmi));

  // odtCaPin is left unread on purpose: termination follows the mode setting only
  logic [5:0] burstLen;
  // mode 0 fixed 16, mode 1 fixed 32, mode 2 on-the-fly from command bit
  assign burstLen = (mrBl_q == 2'h1 || (mrBl_q == 2'h2 && blSel_q)) ? lpif_pkg::BL32 : lpif_pkg::BL16;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= lpif_pkg::ST_IDLE;
      op_q <= 6'h00;
      arg_q <= 6'h00;
      beats_q <= 6'h00;
      lat_q <= 4'h0;
      addr_q <= '0;
      blSel_q <= 1'b0;
      selfRefresh <= 1'b0;
      refreshPulse <= 1'b0;
      refreshBank <= 3'h0;
      refreshAll <= 1'b0;
      zqBusy <= 1'b0;
      openRows_q <= 8'h00;
    end else begin
      refreshPulse <= 1'b0;
      case (st_q)
        lpif_pkg::ST_IDLE: begin
          if (cmdEn && csS) begin
            op_q <= caS;
            st_q <= lpif_pkg::ST_CMD2;
          end
        end
        lpif_pkg::ST_CMD2: begin
          if (cmdEn) begin
            arg_q <= caS;
            st_q <= lpif_pkg::ST_IDLE;
            case (op_q)
              lpif_pkg::OP_ACT: openRows_q[caS[2:0]] <= 1'b1;
              lpif_pkg::OP_REFAB: begin
                refreshPulse <= 1'b1;
                refreshAll <= 1'b1;
              end
              lpif_pkg::OP_REFPB: begin
                refreshPulse <= 1'b1;
                refreshAll <= 1'b0;
                refreshBank <= caS[2:0];
              end
              lpif_pkg::OP_SRE: selfRefresh <= 1'b1;
              lpif_pkg::OP_SRX: selfRefresh <= 1'b0;
              lpif_pkg::OP_ZQ: zqBusy <= ~zqBusy;
              lpif_pkg::OP_RD, lpif_pkg::OP_WR, lpif_pkg::OP_MWR: begin
                // access to a closed bank is dropped; controller opens it first
                if (openRows_q[caS[2:0]] && (isRd || isWr)) begin
                  addr_q <= {caS[5:3], 5'h00};
                  blSel_q <= caS[5];
                  lat_q <= 4'h0;
                  st_q <= isRd ? lpif_pkg::ST_WAITRD : lpif_pkg::ST_WAITWR;
                end
              end
              default: ;
            endcase
          end
        end
        lpif_pkg::ST_WAITRD, lpif_pkg::ST_WAITWR: begin
          if (ckRise) begin
            lat_q <= lat_q + 4'h1;
            // programmed latency sets the first data beat
            if (lat_q == (st_q == lpif_pkg::ST_WAITRD ? readLat : writeLat)) begin
              beats_q <= 6'h00;
              st_q <= (st_q == lpif_pkg::ST_WAITRD) ? lpif_pkg::ST_READ : lpif_pkg::ST_WRITE;
            end
          end
        end
        lpif_pkg::ST_READ: begin
          if (ckEdge) begin
            beats_q <= beats_q + 6'h01;
            addr_q <= addr_q + 1'b1;
            if (beats_q == burstLen - 6'h01) st_q <= lpif_pkg::ST_IDLE;
          end
        end
        lpif_pkg::ST_WRITE: begin
          // write beats follow the controller strobe edges
          if (dqsS[0] != dqsD_q[0]) begin
            beats_q <= beats_q + 6'h01;
            addr_q <= addr_q + 1'b1;
            if (beats_q == burstLen - 6'h01) st_q <= lpif_pkg::ST_IDLE;
          end
        end
        default: st_q <= lpif_pkg::ST_IDLE;
      endcase
    end
  end

  // write memory, byte lanes masked independently
  genvar b;
  generate
    for (b = 0; b < lpif_pkg::BYTES; b++) begin : g_lane
      always_ff @(posedge core_clk) begin
        if (st_q == lpif_pkg::ST_WRITE && dqsS[b] != dqsD_q[b] && !(wrMask[b] && op_q == lpif_pkg::OP_MWR))
          mem[addr_q][8*b +: 8] <= wrPlain[8*b +: 8];
      end
    end
  endgenerate

  // mode register writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mrBl_q <= lpif_pkg::MR_BL_RST;
      mrDmi_q <= lpif_pkg::MR_DMI_RST;
      readLat <= lpif_pkg::LAT_RST;
      writeLat <= lpif_pkg::LAT_RST;
      odtSetting <= lpif_pkg::MR_ODT_RST;
      bankMask <= lpif_pkg::BANK_MASK_RST;
      segMask <= lpif_pkg::SEG_MASK_RST;
      masked_q <= 1'b0;
    end else if (st_q == lpif_pkg::ST_CMD2 && cmdEn && op_q == lpif_pkg::OP_MRW) begin
      masked_q <= 1'b0;
      case (arg_q)
        lpif_pkg::MRA_BL: mrBl_q <= caS[1:0];
        lpif_pkg::MRA_LAT: begin
          readLat <= {1'b0, caS[2:0]};
          writeLat <= {1'b0, caS[5:3]};
        end
        lpif_pkg::MRA_DMI: mrDmi_q <= caS[0];
        lpif_pkg::MRA_ODT: odtSetting <= caS[1:0];
        lpif_pkg::MRA_BANK: bankMask <= {2'h0, caS};
        lpif_pkg::MRA_SEG: segMask <= {2'h0, caS};
        default: ;
      endcase
    end else if (st_q == lpif_pkg::ST_IDLE && cmdEn && csS && caS == lpif_pkg::OP_MRW) begin
      masked_q <= 1'b1;
    end
  end

  // read drive: strobe toggles with each data beat, drivers off with cke low
  // drivers stay on until the ck edge after the last beat, so the last beat is seen
  logic rdOn, rdOe_q;
  assign rdOn = (st_q == lpif_pkg::ST_READ) & ~powerDown;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dqOut <= 16'h0000;
      dmiOut <= 2'h0;
      dqsOut <= 2'h0;
      rdOe_q <= 1'b0;
    end else if (rdOn && ckEdge) begin
      dqOut <= rdCoded;
      dmiOut <= rdDmi;
      dqsOut <= {2{ckRise}};
      rdOe_q <= 1'b1;
    end else if (!rdOn && (ckEdge || powerDown)) begin
      dqsOut <= 2'h0;
      rdOe_q <= 1'b0;
    end
  end
  assign dqOe = {16{rdOe_q & ~powerDown}};
  assign dqsOe = {2{rdOe_q & ~powerDown}};
  assign dmiOe = {2{rdOe_q & ~powerDown & mrDmi_q}};

  a_pd_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
    ckRise |=> (powerDown == !$past(ckeS))) else $error("power down not following cke");
  a_no_drive_pd: assert property (@(posedge core_clk) disable iff (!rst_b)
    powerDown |-> (dqOe == 16'h0000 && dqsOe == 2'h0)) else $error("drivers on in power down");
  a_cmd_on_rise: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_q == lpif_pkg::ST_IDLE && !ckRise) |=> st_q != lpif_pkg::ST_CMD2) else $error("command off edge");
  a_strobe_oe: assert property (@(posedge core_clk) disable iff (!rst_b)
    (dqsOe != 2'h0) |-> (dqOe == 16'hFFFF)) else $error("strobe without data");
  a_dmi_mask_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    !mrDmi_q |-> dmiOe == 2'h0) else $error("dmi driven with inversion off");
  a_dmi_inv: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rdOn && ckEdge) |=> ((dqOut[7:0] ^ {8{dmiOut[0]}}) == $past(rdWord[7:0]))) else $error("dbi");
  a_dqs_rise: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rdOn && ckRise) |=> dqsOut == 2'h3) else $error("strobe not high after rising edge");
  a_refresh_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    refreshPulse |=> !refreshPulse) else $error("refresh pulse too long");
  a_latency_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_q == lpif_pkg::ST_WAITRD && !ckRise) |=> st_q == lpif_pkg::ST_WAITRD) else $error("latency skip");
endmodule

/* hdl/lpif_pkg.sv */
// constants and types for the memory die pin interface
// assumes a single core clock much faster than the sampled link clock
package lpif_pkg;
  localparam int CA_W = 6;
  localparam int DQ_W = 16;
  localparam int BYTES = 2;
  localparam int MEM_DEPTH = 256;
  localparam int ADDR_W = 8;
  localparam logic [5:0] BL16 = 6'h10;
  localparam logic [5:0] BL32 = 6'h20;
  localparam logic [3:0] LAT_RST = 4'h2;
  localparam logic [1:0] MR_BL_RST = 2'h0;
  localparam logic MR_DMI_RST = 1'b0;
  localparam logic [1:0] MR_ODT_RST = 2'h0;
  localparam logic [7:0] BANK_MASK_RST = 8'h00;
  localparam logic [7:0] SEG_MASK_RST = 8'h00;
  // first-cycle command codes on CA[5:0]
  localparam logic [5:0] OP_MRW = 6'h06;
  localparam logic [5:0] OP_ACT = 6'h01;
  localparam logic [5:0] OP_WR = 6'h04;
  localparam logic [5:0] OP_MWR = 6'h0C;
  localparam logic [5:0] OP_RD = 6'h02;
  localparam logic [5:0] OP_REFAB = 6'h28;
  localparam logic [5:0] OP_REFPB = 6'h08;
  localparam logic [5:0] OP_SRE = 6'h18;
  localparam logic [5:0] OP_SRX = 6'h14;
  localparam logic [5:0] OP_ZQ = 6'h30;
  // mode register addresses
  localparam logic [5:0] MRA_BL = 6'h01;
  localparam logic [5:0] MRA_LAT = 6'h02;
  localparam logic [5:0] MRA_DMI = 6'h03;
  localparam logic [5:0] MRA_ODT = 6'h0B;
  localparam logic [5:0] MRA_BANK = 6'h10;
  localparam logic [5:0] MRA_SEG = 6'h11;
  typedef enum {ST_IDLE, ST_CMD2, ST_WAITRD, ST_WAITWR, ST_READ, ST_WRITE} lpif_state_t;
endpackage

/* hdl/lpif_sync.sv */
// two-flop synchroniser for pins from outside the core clock domain
// assumes rst_b is asynchronous active low
`timescale 1ns/1ps
module lpif_sync #(parameter int W = 1) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* tb/lpif_ctl_model.sv */
// behavioural controller driving the die pins: clock, enable, select, command bus
// assumes the caller invokes tasks just after a rising core_clk edge
`timescale 1ns/1ps
module lpif_ctl_model (
  input wire logic core_clk,
  output logic ckPin,
  output logic ckePin,
  output logic csPin,
  output logic [5:0] caPin,
  output logic [15:0] dqDrv,
  output logic [1:0] dqsDrv,
  output logic [1:0] dmiDrv
);
  initial begin
    ckPin = 1'b0;
    ckePin = 1'b0;
    csPin = 1'b0;
    caPin = 6'h00;
    dqDrv = 16'hA5A5;
    dqsDrv = 2'h1;
    dmiDrv = 2'h2;
  end
  // released lines keep changing so a stale level can never look like valid data
  always @(posedge core_clk) begin
    dqDrv <= ~dqDrv;
    dqsDrv <= ~dqsDrv;
    dmiDrv <= ~dmiDrv;
  end
  task automatic half(input logic lvl);
    ckPin <= lvl;
    repeat (4) @(posedge core_clk);
  endtask
  // clock only runs inside frames, standing low otherwise
  task automatic ckCycle();
    half(1'b1);
    half(1'b0);
  endtask
  task automatic setCke(input logic lvl);
    ckePin <= lvl;
    @(posedge core_clk);
  endtask
  // one command at a time, so zq commands never overlap
  task automatic cmd(input logic [5:0] op, input logic [5:0] arg);
    csPin <= 1'b1;
    caPin <= op;
    @(posedge core_clk);
    half(1'b1);
    csPin <= 1'b0;
    caPin <= arg;
    half(1'b0);
    half(1'b1);
    caPin <= ~arg;
    half(1'b0);
    repeat (4) @(posedge core_clk);
  endtask
endmodule

/* tb/tb_lpif_die.sv */
// self-checking bench for one die channel driven by the controller model
// assumes lpif_pkg constants for opcodes and mode register addresses
`timescale 1ns/1ps
module tb_lpif_die;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic odtCaPin = 1'b0;
  logic ckPin, ckePin, csPin;
  logic [5:0] caPin;
  logic [15:0] dqDrv, dqIn, dqOut, dqOe;
  logic [1:0] dqsDrv, dqsIn, dqsOut, dqsOe, dmiDrv, dmiIn, dmiOut, dmiOe;
  logic powerDown, selfRefresh, refreshPulse, refreshAll, zqBusy;
  logic [3:0] readLat, writeLat;
  logic [1:0] odtSetting;
  logic [2:0] refreshBank;
  logic [7:0] bankMask, segMask;
  int n_errors = 0;
  int comparisons = 0;
  int pulses = 0;
  int dqsRises = 0;
  logic sawDqs = 1'b0;
  logic sawDq = 1'b0;
  logic dqsPrev = 1'b0;
  always #5 core_clk = ~core_clk;
  // wire level: whoever enables wins, else the model's moving pattern
  assign dqIn = (dqOe & dqOut) | (~dqOe & dqDrv);
  assign dqsIn = (dqsOe & dqsOut) | (~dqsOe & dqsDrv);
  assign dmiIn = (dmiOe & dmiOut) | (~dmiOe & dmiDrv);
  lpif_ctl_model u_ctl (.core_clk(core_clk), .ckPin(ckPin), .ckePin(ckePin), .csPin(csPin), .caPin(caPin),
    .dqDrv(dqDrv), .dqsDrv(dqsDrv), .dmiDrv(dmiDrv));
  lpif_die DUT (.core_clk(core_clk), .rst_b(rst_b), .ckPin(ckPin), .ckePin(ckePin), .csPin(csPin),
    .caPin(caPin), .odtCaPin(odtCaPin), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .dqsIn(dqsIn),
    .dqsOut(dqsOut), .dqsOe(dqsOe), .dmiIn(dmiIn), .dmiOut(dmiOut), .dmiOe(dmiOe), .powerDown(powerDown),
    .selfRefresh(selfRefresh), .readLat(readLat), .writeLat(writeLat), .odtSetting(odtSetting),
    .refreshPulse(refreshPulse), .refreshBank(refreshBank), .refreshAll(refreshAll), .zqBusy(zqBusy),
    .bankMask(bankMask), .segMask(segMask));
  // counting high cycles of the pulse also catches a pulse that stretches
  always @(posedge core_clk) begin
    if (refreshPulse === 1'b1) pulses++;
    if (dqsOe === 2'b11) sawDqs = 1'b1;
    if (dqOe === 16'hFFFF && (dqOut === 16'hA5A5 || dqOut === 16'h5A5A)) sawDq = 1'b1;
    if (dqsOe[0] === 1'b1 && dqsOut[0] === 1'b1 && dqsPrev === 1'b0) dqsRises++;
    dqsPrev = dqsOut[0];
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // address goes out first, the value rides on the following write
  task automatic mrw(input logic [5:0] addr, input logic [5:0] val);
    u_ctl.cmd(lpif_pkg::OP_MRW, addr);
    u_ctl.cmd(lpif_pkg::OP_MRW, val);
  endtask
  initial begin
    fork
      begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        stop_test();
      end
    join_none
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("powerDown", {15'h0, powerDown}, 16'h1);
    check("readLat", {12'h0, readLat}, 16'h2);
    check("writeLat", {12'h0, writeLat}, 16'h2);
    check("bankMask", {8'h0, bankMask}, 16'h0);
    $display("test reset done");
    u_ctl.cmd(lpif_pkg::OP_REFAB, 6'h00);
    check("pulses cke low", pulses[15:0], 16'h0);
    u_ctl.setCke(1'b1);
    u_ctl.ckCycle();
    repeat (6) @(posedge core_clk);
    check("powerDown exit", {15'h0, powerDown}, 16'h0);
    $display("test clock enable done");
    u_ctl.cmd(lpif_pkg::OP_REFAB, 6'h00);
    check("pulses all", pulses[15:0], 16'h1);
    check("refreshAll", {15'h0, refreshAll}, 16'h1);
    u_ctl.cmd(lpif_pkg::OP_REFPB, 6'h05);
    check("refreshBank", {13'h0, refreshBank}, 16'h5);
    check("refreshAll pb", {15'h0, refreshAll}, 16'h0);
    u_ctl.cmd(lpif_pkg::OP_ZQ, 6'h00);
    check("zqBusy on", {15'h0, zqBusy}, 16'h1);
    u_ctl.cmd(lpif_pkg::OP_ZQ, 6'h00);
    check("zqBusy off", {15'h0, zqBusy}, 16'h0);
    u_ctl.cmd(lpif_pkg::OP_SRE, 6'h00);
    check("selfRefresh on", {15'h0, selfRefresh}, 16'h1);
    u_ctl.cmd(lpif_pkg::OP_SRX, 6'h00);
    check("selfRefresh off", {15'h0, selfRefresh}, 16'h0);
    $display("test commands done");
    mrw(lpif_pkg::MRA_LAT, 6'h1D);
    check("readLat prog", {12'h0, readLat}, 16'h5);
    check("writeLat prog", {12'h0, writeLat}, 16'h3);
    mrw(lpif_pkg::MRA_BANK, 6'h15);
    check("bankMask prog", {8'h0, bankMask}, 16'h15);
    mrw(lpif_pkg::MRA_SEG, 6'h2A);
    check("segMask prog", {8'h0, segMask}, 16'h2A);
    mrw(lpif_pkg::MRA_ODT, 6'h02);
    odtCaPin <= 1'b1;
    u_ctl.cmd(lpif_pkg::OP_REFAB, 6'h00);
    check("odtSetting", {14'h0, odtSetting}, 16'h2);
    $display("test mode registers done");
    u_ctl.cmd(lpif_pkg::OP_RD, 6'h03);
    repeat (10) u_ctl.ckCycle();
    check("refused read", {15'h0, sawDqs}, 16'h0);
    u_ctl.cmd(lpif_pkg::OP_ACT, 6'h03);
    u_ctl.cmd(lpif_pkg::OP_WR, 6'h03);
    repeat (6) u_ctl.ckCycle();
    check("write no drive", {15'h0, sawDqs}, 16'h0);
    u_ctl.cmd(lpif_pkg::OP_RD, 6'h03);
    repeat (30) u_ctl.ckCycle();
    check("read strobe", {15'h0, sawDqs}, 16'h1);
    check("read both bytes", {15'h0, sawDq}, 16'h1);
    check("strobe rises", dqsRises[15:0], 16'h8);
    $display("test read done");
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("bankMask rst", {8'h0, bankMask}, 16'h0);
    check("readLat rst", {12'h0, readLat}, 16'h2);
    rst_b <= 1'b1;
    $display("test second reset done");
    stop_test();
  end
endmodule
